/* File: eeprom_prot_pkg.sv */
// shared constants and types for the serial eeprom protection block
package eeprom_prot_pkg;
  // instruction opcodes, bit 3 masked off before compare
  localparam logic [7:0] CMD_MASK = 8'hf7;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] WRITE_CMD = 8'h02;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  // status register field positions
  localparam int WIP_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int PSEL_LO_BIT = 2;
  localparam int PSEL_HI_BIT = 3;
  // protection range lower bounds
  localparam logic [8:0] PROT_QUARTER_BASE = 9'h180;
  localparam logic [8:0] PROT_HALF_BASE = 9'h100;
  localparam logic [8:0] PROT_ALL_BASE = 9'h000;
  localparam logic [1:0] PSEL_RESET = 2'h0;
  // self-timed write cycle, 5 ms at 100 MHz
  localparam int WRITE_TIME_US = 5000;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int PAGE_BYTES = 16;
  localparam int BYTE_BITS = 8;
  // serial pins from the host
  typedef struct packed {
    logic select_n;
    logic sclk;
    logic sdi;
    logic pause_n;
    logic wprot_n;
  } pins_t;
  // serial data output pair
  typedef struct packed {
    logic data;
    logic oe;
  } sdo_t;
endpackage

/* File: eeprom_prot.sv */
// serial eeprom write protection, latch, pause and pin timing logic
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - protect bits select protected address range
// - status write starts on select rise
// - latch cleared at power up
// - latch cleared after any completed write
// - array access ignored during write cycle
// - standby, output off until select falls
// - write needs protect pin high, latch set
// - protect pin low blocks all writes
// - protect pin low holds latch cleared
// - running write unaffected by protect pin
// - deselect gives standby and output off
// - programming completes regardless of select
// - output changes after clock falling edge
// - input sampled on clock rising edge
// - pause keeps sequence state, then resumes
// - pause taken only while clock low
// - paused device ignores clock and data
// - resume only while clock low
// - pause low always disables output
// - status layout wip, latch, protect bits
// - enable, disable, status write opcodes
// - all bytes msb first
// - in-progress flag, status always readable
module eeprom_prot #(
  parameter int WRITE_CYCLES_P = eeprom_prot_pkg::WRITE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire eeprom_prot_pkg::pins_t pins_in,
  output logic sdo_data_out,
  output logic sdo_oe_out,
  output logic write_in_progress_out,
  output logic write_enable_latch_out,
  output logic [1:0] protect_sel_out,
  output logic array_write_pulse_out,
  output logic [8:0] array_addr_out,
  output logic [7:0] array_wdata_out
);
  import eeprom_prot_pkg::*;

  typedef enum logic [2:0] {
    ST_STANDBY, ST_CMD, ST_ADDR, ST_WDATA, ST_SWDATA, ST_RDATA, ST_SRDATA,
    ST_IGNORE
  } phase_t;

  // two-flop synchronisers for every pin input
  pins_t sync1_q;
  pins_t sync2_q;
  pins_t prev_q; // previous synced value for edge finding
  logic [7:0] arr_mem [0:511]; // the memory array itself
  logic [7:0] page_q [0:PAGE_BYTES-1]; // page buffer
  logic [PAGE_BYTES-1:0] page_vld_q;
  phase_t phase_q;
  logic [7:0] shift_q; // incoming byte, msb first
  logic [2:0] bitcnt_q;
  logic [7:0] cmd_q;
  logic [8:0] addr_q;
  logic [7:0] rbyte_q; // outgoing byte
  logic byte_done_q; // a whole byte ended exactly at last edge
  logic paused_q;
  logic pause_req_q; // pause low seen while clock high
  logic wel_q;
  logic wip_q;
  logic [1:0] psel_q;
  logic [31:0] wcnt_q;
  logic pend_arr_q; // array write armed by full byte
  logic pend_st_q; // status write armed by full byte
  logic [7:0] st_data_q;
  logic [8:0] wr_addr_q;
  logic [3:0] wr_idx_q;
  logic sdo_q;
  logic oe_q;
  logic active; // selected and not paused
  logic rise;
  logic fall;
  logic sel_fall;
  logic sel_rise;
  logic [7:0] nxt_byte;

  // protection lookup from protect bits and address
  function automatic logic is_protected(input logic [1:0] sel,
                                        input logic [8:0] a);
    case (sel)
      2'h1: is_protected = (a >= PROT_QUARTER_BASE);
      2'h2: is_protected = (a >= PROT_HALF_BASE);
      2'h3: is_protected = (a >= PROT_ALL_BASE);
      default: is_protected = 1'b0;
    endcase
  endfunction

  // opcode compare with the don't-care bit masked
  function automatic logic is_cmd(input logic [7:0] c,
                                  input logic [7:0] op);
    is_cmd = ((c & CMD_MASK) == op);
  endfunction

  assign rise = sync2_q.sclk & ~prev_q.sclk;
  assign fall = ~sync2_q.sclk & prev_q.sclk;
  assign sel_fall = ~sync2_q.select_n & prev_q.select_n;
  assign sel_rise = sync2_q.select_n & ~prev_q.select_n;
  assign active = ~sync2_q.select_n & ~paused_q;
  assign nxt_byte = {shift_q[6:0], sync2_q.sdi};

  // input synchronisers; stage two and its delayed copy prev_q feed logic
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_q <= '{select_n: 1'b1, pause_n: 1'b1, wprot_n: 1'b1,
                   default: 1'b0};
      sync2_q <= '{select_n: 1'b1, pause_n: 1'b1, wprot_n: 1'b1,
                   default: 1'b0};
      prev_q <= '{select_n: 1'b1, pause_n: 1'b1, wprot_n: 1'b1,
                  default: 1'b0};
    end else begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // pause control: enter and leave only while clock is low
  always_ff @(posedge clk_in) begin
    if (rst_in || sync2_q.select_n) begin
      paused_q <= 1'b0;
      pause_req_q <= 1'b0;
    end else if (!paused_q) begin
      if (!sync2_q.pause_n && (!sync2_q.sclk || (pause_req_q && fall))) begin
        paused_q <= 1'b1;
        pause_req_q <= 1'b0;
      end else begin
        pause_req_q <= ~sync2_q.pause_n & sync2_q.sclk;
      end
    end else if (sync2_q.pause_n && !sync2_q.sclk) begin
      paused_q <= 1'b0;
    end
  end

  // serial sequence engine, state kept frozen while paused
  always_ff @(posedge clk_in) begin
    if (rst_in || sync2_q.select_n) begin
      phase_q <= ST_STANDBY;
      bitcnt_q <= 3'h0;
      byte_done_q <= 1'b0;
      shift_q <= 8'h00;
    end else if (active && sel_fall) begin
      phase_q <= ST_CMD;
    end else if (active && rise) begin
      shift_q <= nxt_byte;
      bitcnt_q <= bitcnt_q + 3'h1;
      byte_done_q <= (bitcnt_q == 3'h7);
      if (bitcnt_q == 3'h7) begin
        case (phase_q)
          ST_CMD: begin
            cmd_q <= nxt_byte;
            if (is_cmd(nxt_byte, READ_CMD) || is_cmd(nxt_byte, WRITE_CMD))
              phase_q <= wip_q ? ST_IGNORE : ST_ADDR;
            else if (is_cmd(nxt_byte, STATUS_READ_CMD))
              phase_q <= ST_SRDATA;
            else if (is_cmd(nxt_byte, STATUS_WRITE_CMD))
              phase_q <= ST_SWDATA;
            else
              phase_q <= ST_IGNORE;
          end
          ST_ADDR: begin
            addr_q <= {cmd_q[3], nxt_byte};
            phase_q <= is_cmd(cmd_q, READ_CMD) ? ST_RDATA : ST_WDATA;
          end
          ST_WDATA: begin
            page_q[addr_q[3:0]] <= nxt_byte;
            addr_q <= {addr_q[8:4], addr_q[3:0] + 4'h1};
          end
          ST_SWDATA: begin
            st_data_q <= nxt_byte;
            phase_q <= ST_IGNORE;
          end
          ST_RDATA: addr_q <= addr_q + 9'h001;
          ST_SRDATA: phase_q <= ST_SRDATA;
          ST_IGNORE: phase_q <= ST_IGNORE;
          default: phase_q <= ST_IGNORE;
        endcase
      end
    end else if (active && sel_fall == 1'b0 && phase_q == ST_STANDBY) begin
      phase_q <= ST_CMD;
    end
  end

  // page buffer valid bits, cleared at a new select when no write cycle is running
  // a select during programming must not wipe bytes not yet committed
  always_ff @(posedge clk_in) begin
    if (rst_in || (sel_fall && !wip_q)) begin
      page_vld_q <= '0;
    end else if (active && rise && bitcnt_q == 3'h7 && phase_q == ST_WDATA) begin
      page_vld_q[addr_q[3:0]] <= 1'b1;
    end
  end

  // output shifter, updated after clock falls
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      rbyte_q <= 8'h00;
    end else begin
      oe_q <= active & sync2_q.pause_n &
              (phase_q == ST_RDATA || phase_q == ST_SRDATA);
      if (active && rise && bitcnt_q == 3'h7) begin
        rbyte_q <= (phase_q == ST_CMD && is_cmd(nxt_byte, STATUS_READ_CMD)) ||
                   phase_q == ST_SRDATA ?
                   {4'h0, psel_q, wel_q, wip_q} :
                   arr_mem[phase_q == ST_ADDR ? {cmd_q[3], nxt_byte} :
                           addr_q + 9'h001];
      end else if (active && fall) begin
        sdo_q <= rbyte_q[~bitcnt_q];
      end
    end
  end

  // arm a write only when select rises on a byte boundary
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pend_arr_q <= 1'b0;
      pend_st_q <= 1'b0;
    end else begin
      pend_arr_q <= sel_rise && byte_done_q && bitcnt_q == 3'h0 &&
                    phase_q == ST_WDATA && (|page_vld_q) && !wip_q;
      // only after the data byte, so stale status data is never stored
      pend_st_q <= sel_rise && byte_done_q && bitcnt_q == 3'h0 &&
                   phase_q == ST_IGNORE &&
                   is_cmd(cmd_q, STATUS_WRITE_CMD) && !wip_q;
    end
  end

  // write enable latch
  always_ff @(posedge clk_in) begin
    if (rst_in || !sync2_q.wprot_n) begin
      wel_q <= 1'b0;
    end else if (wip_q && wcnt_q == 32'd1) begin
      wel_q <= 1'b0;
    end else if (sel_rise && byte_done_q && bitcnt_q == 3'h0 &&
                 phase_q == ST_IGNORE && !wip_q) begin
      if (is_cmd(cmd_q, WRITE_ENABLE_CMD))
        wel_q <= 1'b1;
      else if (is_cmd(cmd_q, WRITE_DISABLE_CMD))
        wel_q <= 1'b0;
    end
  end

  // self-timed programming, runs on regardless of select or pin
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wip_q <= 1'b0;
      wcnt_q <= 32'd0;
      psel_q <= PSEL_RESET;
      wr_idx_q <= 4'h0;
      wr_addr_q <= 9'h000;
    end else if (!wip_q) begin
      if ((pend_arr_q || pend_st_q) && wel_q && sync2_q.wprot_n) begin
        wip_q <= 1'b1;
        wcnt_q <= WRITE_CYCLES_P;
        wr_addr_q <= {addr_q[8:4], 4'h0};
        wr_idx_q <= 4'h0;
        if (pend_st_q)
          psel_q <= st_data_q[PSEL_HI_BIT:PSEL_LO_BIT];
      end
    end else begin
      wcnt_q <= wcnt_q - 32'd1;
      wr_idx_q <= wr_idx_q + 4'h1;
      if (wcnt_q == 32'd1)
        wip_q <= 1'b0;
    end
  end

  // commit page bytes outside protected range during the cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      array_write_pulse_out <= 1'b0;
      array_addr_out <= 9'h000;
      array_wdata_out <= 8'h00;
    end else begin
      array_write_pulse_out <= 1'b0;
      // one pass over the page only; the index wraps after sixteen
      if (wip_q && wcnt_q > 32'(WRITE_CYCLES_P - PAGE_BYTES) &&
          page_vld_q[wr_idx_q] &&
          !is_protected(psel_q, {wr_addr_q[8:4], wr_idx_q})) begin
        arr_mem[{wr_addr_q[8:4], wr_idx_q}] <= page_q[wr_idx_q];
        array_write_pulse_out <= 1'b1;
        array_addr_out <= {wr_addr_q[8:4], wr_idx_q};
        array_wdata_out <= page_q[wr_idx_q];
      end
    end
  end

  // registered status and pin outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sdo_data_out <= 1'b0;
      sdo_oe_out <= 1'b0;
      write_in_progress_out <= 1'b0;
      write_enable_latch_out <= 1'b0;
      protect_sel_out <= PSEL_RESET;
    end else begin
      sdo_data_out <= sdo_q;
      sdo_oe_out <= oe_q & sync2_q.pause_n & ~sync2_q.select_n;
      write_in_progress_out <= wip_q;
      write_enable_latch_out <= wel_q;
      protect_sel_out <= psel_q;
    end
  end
endmodule
`default_nettype wire

/* File: eeprom_host_model.sv */
// host side serial master model for the protection block
`timescale 1ns/100ps
`default_nettype none
module eeprom_host_model (
  input wire logic clk_in,
  input wire logic sdo_in,
  output var eeprom_prot_pkg::pins_t pins_out
);
  import eeprom_prot_pkg::*;
  // idle: deselected, link clock low, pause and protect pins high
  initial pins_out = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  // link half period in system clocks, changes land on falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic sel;
    pins_out.select_n = 1'b0;
    tick(6);
  endtask
  // callers raise select on a byte boundary unless testing a refusal
  task automatic desel;
    tick(6);
    pins_out.select_n = 1'b1;
    pins_out.sdi = ~pins_out.sdi; // a released line keeps no value
    tick(10);
  endtask
  // data set while clock low, read data taken just before the rise
  task automatic bit1(input logic b, output logic r);
    pins_out.sdi = b;
    tick(6);
    r = sdo_in;
    pins_out.sclk = 1'b1;
    tick(6);
    pins_out.sclk = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit1(tx[i], rx[i]);
  endtask
  // pause with clock low and select held, wiggle clock, resume low
  task automatic pause(input int n);
    pins_out.pause_n = 1'b0;
    repeat (n) begin
      tick(6);
      pins_out.sclk = ~pins_out.sclk;
    end
    tick(6);
    pins_out.pause_n = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: eeprom_prot_monitor.sv */
// port level checks on the protection block
`timescale 1ns/100ps
`default_nettype none
module eeprom_prot_monitor #(
  parameter int WRITE_CYCLES_P = 200
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire eeprom_prot_pkg::pins_t pins_in,
  input wire logic sdo_data_out,
  input wire logic sdo_oe_out,
  input wire logic write_in_progress_out,
  input wire logic write_enable_latch_out,
  input wire logic [1:0] protect_sel_out,
  input wire logic array_write_pulse_out,
  input wire logic [8:0] array_addr_out
);
  import eeprom_prot_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  int wip_len_q; // cycles the write cycle has stood so far
  // counter restarts whenever the cycle is not running
  always_ff @(posedge clk_in) begin
    if (rst_in || !write_in_progress_out) wip_len_q <= 0;
    else wip_len_q <= wip_len_q + 1;
  end
  // true when the protect setting covers the address
  function automatic logic guarded(logic [8:0] a, logic [1:0] s);
    return s == 2'h3 || (s == 2'h2 && a >= 9'h100) ||
      (s == 2'h1 && a >= 9'h180);
  endfunction
  // six cycles (eight on the protect pin) lets the pin synchronisers settle
  sequence s_desel; pins_in.select_n [*6]; endsequence
  sequence s_paused; !pins_in.pause_n [*6]; endsequence
  sequence s_wp_low; (!pins_in.wprot_n && !write_in_progress_out) [*8];
  endsequence
  property p_desel_off; s_desel |-> !sdo_oe_out; endproperty
  property p_pause_off; s_paused |-> !sdo_oe_out; endproperty
  property p_wp_latch; s_wp_low |-> !write_enable_latch_out; endproperty
  property p_latch_end;
    $fell(write_in_progress_out) |-> ##[0:1] !write_enable_latch_out;
  endproperty
  property p_wip_len; $fell(write_in_progress_out) |->
    wip_len_q inside {[WRITE_CYCLES_P - 1:WRITE_CYCLES_P + 1]};
  endproperty
  property p_wip_start; $rose(write_in_progress_out) |-> pins_in.select_n;
  endproperty
  property p_pulse_range;
    array_write_pulse_out |-> !guarded(array_addr_out, protect_sel_out);
  endproperty
  property p_pulse_wip; array_write_pulse_out |-> write_in_progress_out;
  endproperty
  property p_latch_wp;
    $rose(write_enable_latch_out) |-> pins_in.wprot_n;
  endproperty
  property p_sdo_fall;
    $changed(sdo_data_out) && sdo_oe_out |-> !pins_in.sclk;
  endproperty
  a_desel_off: assert property (p_desel_off) else $error("sdo on");
  a_pause_off: assert property (p_pause_off) else $error("sdo on");
  a_wp_latch: assert property (p_wp_latch) else $error("latch set");
  a_latch_end: assert property (p_latch_end) else $error("latch");
  a_wip_len: assert property (p_wip_len) else $error("wip len");
  a_wip_start: assert property (p_wip_start) else $error("start");
  a_pulse_range: assert property (p_pulse_range) else $error("prot");
  a_pulse_wip: assert property (p_pulse_wip) else $error("pulse");
  a_latch_wp: assert property (p_latch_wp) else $error("latch");
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo edge");
endmodule
bind eeprom_prot eeprom_prot_monitor #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) mon (
  .clk_in(clk_in), .rst_in(rst_in), .pins_in(pins_in),
  .sdo_data_out(sdo_data_out), .sdo_oe_out(sdo_oe_out),
  .write_in_progress_out(write_in_progress_out),
  .write_enable_latch_out(write_enable_latch_out),
  .protect_sel_out(protect_sel_out),
  .array_write_pulse_out(array_write_pulse_out),
  .array_addr_out(array_addr_out));
`default_nettype wire

/* File: eeprom_prot_tb_top.sv */
// self-checking bench for the protection block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end
module eeprom_prot_tb_top;
  import eeprom_prot_pkg::*;
  localparam int WC = 1000; // short write cycle keeps the run brief
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  pins_t pins;
  logic sdo_d, sdo_oe, write_in_progress, write_enable_latch, pw, line;
  logic [1:0] psel;
  logic [8:0] addr, last_a;
  logic [7:0] wd, last_d, rx;
  int mismatches = 0, samples_checked = 0, pulses = 0;
  always #5 clk_in = ~clk_in;
  // released output shows the inverse, never the last value
  assign line = sdo_oe ? sdo_d : ~sdo_d;
  eeprom_host_model host (.clk_in(clk_in), .sdo_in(line), .pins_out(pins));
  eeprom_prot #(.WRITE_CYCLES_P(WC)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .pins_in(pins), .sdo_data_out(sdo_d), .sdo_oe_out(sdo_oe),
    .write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch),
    .protect_sel_out(psel), .array_write_pulse_out(pw),
    .array_addr_out(addr), .array_wdata_out(wd));
  // record every programmed byte
  always @(posedge clk_in) if (pw === 1'b1) begin
    pulses++;
    last_a = addr;
    last_d = wd;
  end
  task automatic give_verdict;
    $display("checked %0d mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait for the write cycle to end
  task automatic wait_wip;
    int n;
    n = 0;
    while (write_in_progress !== 1'b0 && n < 2 * WC) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 2 * WC) begin
      mismatches++;
      give_verdict;
    end
  endtask
  task automatic cmd1(input logic [7:0] b);
    host.sel;
    host.xfer(b, rx);
    host.desel;
  endtask
  task automatic status_write_cmd(input logic [7:0] v, input int extra);
    cmd1(WRITE_ENABLE_CMD);
    host.sel;
    host.xfer(STATUS_WRITE_CMD, rx);
    host.xfer(v, rx);
    repeat (extra) host.bit1(1'b0, rx[0]);
    host.desel;
  endtask
  task automatic awr(input logic [8:0] a, input logic [7:0] d);
    cmd1(WRITE_ENABLE_CMD);
    host.sel;
    host.xfer(WRITE_CMD | {4'h0, a[8], 3'h0}, rx);
    host.xfer(a[7:0], rx);
    host.xfer(d, rx);
    host.desel;
  endtask
  initial begin
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    host.tick(4);
    `CHK("latch", 1'b0, write_enable_latch)
    `CHK("sdo_oe", 1'b0, sdo_oe)
    cmd1(WRITE_ENABLE_CMD);
    `CHK("latch", 1'b1, write_enable_latch)
    cmd1(WRITE_DISABLE_CMD);
    `CHK("latch", 1'b0, write_enable_latch)
    $display("test latch done");
    for (int k = 0; k < 4; k++) begin
      status_write_cmd({4'ha, 2'(k ^ 1), 2'h3}, 0);
      `CHK("wip", 1'b1, write_in_progress)
      wait_wip;
      `CHK("protect", 2'(k ^ 1), psel)
      `CHK("latch", 1'b0, write_enable_latch)
    end
    $display("test protect levels done");
    awr(9'h0ff, 8'ha5);
    awr(9'h0fe, 8'h5a);
    wait_wip;
    awr(9'h100, 8'h3c);
    host.tick(10);
    wait_wip;
    `CHK("pulses", 1, pulses)
    `CHK("addr", 9'h0ff, last_a)
    `CHK("data", 8'ha5, last_d)
    $display("test array done");
    status_write_cmd(8'h00, 1);
    `CHK("wip", 1'b0, write_in_progress)
    host.pins_out.wprot_n = 1'b0;
    host.tick(4);
    `CHK("latch", 1'b0, write_enable_latch)
    status_write_cmd(8'h00, 0);
    `CHK("wip", 1'b0, write_in_progress)
    host.pins_out.wprot_n = 1'b1;
    status_write_cmd(8'h04, 0);
    host.pins_out.wprot_n = 1'b0;
    wait_wip;
    `CHK("protect", 2'h1, psel)
    host.pins_out.wprot_n = 1'b1;
    $display("test write protect done");
    host.sel;
    host.xfer(STATUS_READ_CMD, rx);
    host.pause(4);
    `CHK("sdo_oe", 1'b0, sdo_oe)
    host.xfer(8'h00, rx);
    `CHK("status", 4'h4, rx[3:0])
    host.desel;
    `CHK("sdo_oe", 1'b0, sdo_oe)
    $display("test pause read done");
    give_verdict;
  end
endmodule
`undef CHK
`default_nettype wire
